// ===== logic/ovt_pkg.sv
package ovt_pkg;
   localparam int NCH = 3;
   localparam int SPD_W = 16;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_SETPT0 = 8'h0c;
   localparam logic [7:0] OFS_SPEED0 = 8'h18;
   localparam logic [7:0] OFS_PEAK = 8'h24;
   // Control fields
   localparam int CTRL_TWO_CH = 0;
   localparam int CTRL_AUTO_OPT = 1;
   localparam int CTRL_TEST_LSB = 4;
   // Command fields
   localparam int CMD_LATCH_RST = 0;
   localparam int CMD_PEAK_RST = 1;
   localparam int CMD_AUTO_GO = 2;
   // Reset values
   localparam logic [SPD_W-1:0] SETPT_RST = 16'h0fa0;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int GATE_TIME_US = 10000;
   localparam int GATE_CYCLES = GATE_TIME_US * CLK_MHZ;
   localparam int TRIP_LIMIT_MS = 40;
   // Response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   typedef struct packed {
      logic [NCH-1:0] test_en;
      logic auto_opt;
      logic two_ch;
   } ovt_ctrl_t;

   typedef struct packed {
      logic os_alarm;
      logic os_trip;
      logic [NCH-1:0] flt_alarm;
      logic flt_trip;
   } ovt_latch_t;

   typedef enum logic [1:0] {
      AT_IDLE = 2'b00,
      AT_SETTLE = 2'b01,
      AT_MEASURE = 2'b11,
      AT_NEXT = 2'b10
   } ovt_at_state_t;
endpackage : ovt_pkg

// ===== logic/ovt_top.sv
// Two-flop synchroniser for one asynchronous level
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
module ovt_sync (
   input wire logic clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   logic meta_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : ovt_sync

module ovt_top
   import ovt_pkg::*;
#(
   parameter int GATE_CYC = GATE_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] sensor_pulse,
   input wire logic [NCH-1:0] test_freq_in,
   input wire logic [NCH-1:0] chan_fail,
   input wire logic manual_reset,
   input wire logic access_key,
   output logic [NCH-1:0] shutdown_relay,
   output logic [NCH-1:0] fault_relay,
   output logic overspeed_alarm,
   output logic [NCH-1:0][SPD_W-1:0] speed_readout,
   output logic [SPD_W-1:0] peak_speed
);
   logic [NCH-1:0] sens_s, test_s, fail_s, src_prev_reg, src_sel;
   logic mrst_s, mrst_prev_reg, key_s;
   logic [19:0] gate_cnt_reg;
   logic gate_end;
   logic [NCH-1:0][SPD_W-1:0] pulse_cnt_reg, speed_reg, setpt_reg;
   logic [NCH-1:0] os_reg, os_m, fail_m;
   logic [SPD_W-1:0] peak_reg, speed_max;
   ovt_ctrl_t ctrl_reg;
   ovt_latch_t latch_reg;
   logic vote_os, vote_fail, any_os, any_fail, clr;
   ovt_at_state_t at_state_reg;
   logic [1:0] at_ch_reg;
   logic [NCH-1:0] at_pass_reg;
   logic aw_full_reg, w_full_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_do, wr_ok, wr_hit, rd_do, rd_hit;
   logic cmd_latch_rst, cmd_peak_rst, cmd_auto_go;
   logic [31:0] rdata_next;
   logic [1:0] wr_idx;

   // Every asynchronous pin passes two flip-flops
   for (genvar i = 0; i < NCH; i++) begin : g_sync
      ovt_sync u_sens (.clk(clk), .nrst(nrst), .d(sensor_pulse[i]),
         .q(sens_s[i]));
      ovt_sync u_test (.clk(clk), .nrst(nrst), .d(test_freq_in[i]),
         .q(test_s[i]));
      ovt_sync u_fail (.clk(clk), .nrst(nrst), .d(chan_fail[i]),
         .q(fail_s[i]));
   end
   ovt_sync u_mrst (.clk(clk), .nrst(nrst), .d(manual_reset), .q(mrst_s));
   ovt_sync u_key (.clk(clk), .nrst(nrst), .d(access_key), .q(key_s));

   // Test generator replaces the sensor per circuit
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         src_sel[i] = ctrl_reg.test_en[i] ? test_s[i] : sens_s[i];
         if (at_state_reg != AT_IDLE && at_ch_reg == 2'(i)) begin
            src_sel[i] = test_s[i];
         end
      end
   end

   // Fixed gate time shared by all circuits
   assign gate_end = (gate_cnt_reg == 20'(GATE_CYC - 1));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gate_cnt_reg <= 20'h00000;
      end else if (gate_end) begin
         gate_cnt_reg <= 20'h00000;
      end else begin
         gate_cnt_reg <= gate_cnt_reg + 20'h00001;
      end
   end

   // Pulse counting, speed capture and setpoint compare
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         src_prev_reg <= '0;
         pulse_cnt_reg <= '0;
         speed_reg <= '0;
         os_reg <= '0;
      end else begin
         src_prev_reg <= src_sel;
         for (int i = 0; i < NCH; i++) begin
            if (gate_end) begin
               speed_reg[i] <= pulse_cnt_reg[i];
               os_reg[i] <= (pulse_cnt_reg[i] > setpt_reg[i]);
               pulse_cnt_reg[i] <= (src_sel[i] && !src_prev_reg[i]) ?
                  16'h0001 : 16'h0000;
            end else if (src_sel[i] && !src_prev_reg[i] &&
                         pulse_cnt_reg[i] != 16'hffff) begin
               pulse_cnt_reg[i] <= pulse_cnt_reg[i] + 16'h0001;
            end
         end
      end
   end

   // Voting; third circuit ignored in two-circuit mode
   assign os_m = ctrl_reg.two_ch ? {1'b0, os_reg[1:0]} : os_reg;
   assign fail_m = ctrl_reg.two_ch ? {1'b0, fail_s[1:0]} : fail_s;
   assign any_os = |os_m;
   assign vote_os = ctrl_reg.two_ch ? (os_m[0] | os_m[1]) :
      ((os_m[0] & os_m[1]) | (os_m[0] & os_m[2]) |
       (os_m[1] & os_m[2]));
   assign any_fail = |fail_m;
   assign vote_fail = (fail_m[0] & fail_m[1]) | (fail_m[0] & fail_m[2]) |
      (fail_m[1] & fail_m[2]);

   // Operator reset from pin edge or bus command
   assign clr = (mrst_s && !mrst_prev_reg) || cmd_latch_rst;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mrst_prev_reg <= 1'b0;
      end else begin
         mrst_prev_reg <= mrst_s;
      end
   end

   // Latched conditions; set wins, clear needs cause gone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch_reg <= '0;
      end else begin
         latch_reg.os_alarm <= any_os ||
            (latch_reg.os_alarm && !clr);
         latch_reg.os_trip <= vote_os ||
            (latch_reg.os_trip && !clr);
         latch_reg.flt_trip <= vote_fail ||
            (latch_reg.flt_trip && !clr);
         for (int i = 0; i < NCH; i++) begin
            latch_reg.flt_alarm[i] <= fail_m[i] ||
               (latch_reg.flt_alarm[i] && !clr);
         end
      end
   end

   // Relay drive straight from latches; nothing masks it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shutdown_relay <= '0;
         fault_relay <= '0;
         overspeed_alarm <= 1'b0;
      end else begin
         shutdown_relay <= {NCH{latch_reg.os_trip |
            latch_reg.flt_trip}};
         fault_relay <= latch_reg.flt_alarm;
         overspeed_alarm <= latch_reg.os_alarm;
      end
   end

   // Speed readout and peak hold
   always_comb begin
      speed_max = speed_reg[0];
      for (int i = 1; i < NCH; i++) begin
         if (speed_reg[i] > speed_max) begin
            speed_max = speed_reg[i];
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         peak_reg <= '0;
         speed_readout <= '0;
         peak_speed <= '0;
      end else begin
         speed_readout <= speed_reg;
         peak_speed <= peak_reg;
         if (cmd_peak_rst) begin
            peak_reg <= speed_max;
         end else if (speed_max > peak_reg) begin
            peak_reg <= speed_max;
         end
      end
   end

   // Automatic test: each circuit on test input for a settle gate and a measure gate; circuit 2 skipped in two-circuit mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         at_state_reg <= AT_IDLE;
         at_ch_reg <= 2'b00;
         at_pass_reg <= '0;
      end else begin
         unique case (at_state_reg)
            AT_IDLE: begin
               if (cmd_auto_go && ctrl_reg.auto_opt) begin
                  at_state_reg <= AT_SETTLE;
                  at_ch_reg <= 2'b00;
                  at_pass_reg <= '0;
               end
            end
            AT_SETTLE: begin
               if (gate_end) begin
                  at_state_reg <= AT_MEASURE;
               end
            end
            AT_MEASURE: begin
               if (gate_end) begin
                  at_pass_reg[at_ch_reg] <=
                     (pulse_cnt_reg[at_ch_reg] > setpt_reg[at_ch_reg]);
                  at_state_reg <= AT_NEXT;
               end
            end
            AT_NEXT: begin
               if (at_ch_reg == 2'(NCH - 1) ||
                   (ctrl_reg.two_ch && at_ch_reg == 2'b01)) begin
                  at_state_reg <= AT_IDLE;
               end else begin
                  at_ch_reg <= at_ch_reg + 2'b01;
                  at_state_reg <= AT_SETTLE;
               end
            end
         endcase
      end
   end

   // Write address and data are taken in either order
   assign wr_do = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_idx = 2'((awaddr_reg - OFS_SETPT0) >> 2);
   assign wr_hit = (awaddr_reg == OFS_CTRL) || (awaddr_reg == OFS_CMD) ||
      (awaddr_reg >= OFS_SETPT0 && awaddr_reg < OFS_SPEED0 &&
       awaddr_reg[1:0] == 2'b00);
   assign wr_ok = key_s || (awaddr_reg == OFS_CMD);
   assign cmd_latch_rst = wr_do && awaddr_reg == OFS_CMD &&
      wstrb_reg[0] && wdata_reg[CMD_LATCH_RST];
   assign cmd_peak_rst = wr_do && key_s && awaddr_reg == OFS_CMD &&
      wstrb_reg[0] && wdata_reg[CMD_PEAK_RST];
   assign cmd_auto_go = wr_do && key_s && awaddr_reg == OFS_CMD &&
      wstrb_reg[0] && wdata_reg[CMD_AUTO_GO];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
            aw_full_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= !wr_hit ? RESP_DECERR :
               (wr_ok ? RESP_OKAY : RESP_SLVERR);
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Settings change only while the access key is on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= '0;
         setpt_reg <= {NCH{SETPT_RST}};
      end else if (wr_do && key_s) begin
         if (awaddr_reg == OFS_CTRL && wstrb_reg[0]) begin
            ctrl_reg.two_ch <= wdata_reg[CTRL_TWO_CH];
            ctrl_reg.auto_opt <= wdata_reg[CTRL_AUTO_OPT];
            ctrl_reg.test_en <=
               wdata_reg[CTRL_TEST_LSB +: NCH];
         end
         if (wr_hit && awaddr_reg >= OFS_SETPT0 &&
             awaddr_reg < OFS_SPEED0) begin
            if (wstrb_reg[0]) begin
               setpt_reg[wr_idx][7:0] <= wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
               setpt_reg[wr_idx][15:8] <= wdata_reg[15:8];
            end
         end
      end
   end

   // Read decode: status only, no effect on trip path
   assign rd_do = s_axi_arvalid && s_axi_arready;
   always_comb begin
      rdata_next = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         OFS_CTRL: rdata_next = {25'h0000000, ctrl_reg.test_en,
            2'b00, ctrl_reg.auto_opt, ctrl_reg.two_ch};
         OFS_CMD: rdata_next = 32'h00000000;
         OFS_STATUS: rdata_next = {13'h0000, at_pass_reg,
            (at_state_reg != AT_IDLE), key_s, latch_reg.flt_trip,
            latch_reg.flt_alarm, latch_reg.os_trip, latch_reg.os_alarm,
            1'b0, fail_s, 1'b0, os_reg};
         OFS_PEAK: rdata_next = {16'h0000, peak_reg};
         default: begin
            if (s_axi_araddr >= OFS_SETPT0 && s_axi_araddr < OFS_SPEED0 &&
                s_axi_araddr[1:0] == 2'b00) begin
               rdata_next = {16'h0000, setpt_reg[
                  2'((s_axi_araddr - OFS_SETPT0) >> 2)]};
            end else if (s_axi_araddr >= OFS_SPEED0 &&
                         s_axi_araddr < OFS_PEAK &&
                         s_axi_araddr[1:0] == 2'b00) begin
               rdata_next = {16'h0000, speed_reg[
                  2'((s_axi_araddr - OFS_SPEED0) >> 2)]};
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_do) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_next;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule : ovt_top

// ===== test/ovt_properties.sv
module ovt_chk
   import ovt_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp,
   input wire logic manual_reset,
   input wire logic [NCH-1:0] chan_fail,
   input wire logic [NCH-1:0] shutdown_relay,
   input wire logic [NCH-1:0] fault_relay,
   input wire logic overspeed_alarm,
   input wire logic [SPD_W-1:0] peak_speed
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic [3:0] age_reg;
   // Cycles since the last operator reset or bus write response, saturating at 15
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         age_reg <= 4'h0;
      end else if (manual_reset || s_axi_bvalid) begin
         age_reg <= 4'h0;
      end else if (age_reg != 4'hf) begin
         age_reg <= age_reg + 4'h1;
      end
   end
   // Bus handshakes
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_answer;
      s_wr_take |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer late");
   property p_rd_answer;
      s_rd_take |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer late");
   property p_decerr;
      s_rd_take ##0 (s_axi_araddr >= 8'h28) |=> s_axi_rresp == RESP_DECERR;
   endproperty
   a_decerr: assert property (p_decerr)
      else $error("unmapped read not refused");
   // Trip path
   property p_relays_eq;
      shutdown_relay == {NCH{shutdown_relay[0]}};
   endproperty
   a_relays_eq: assert property (p_relays_eq)
      else $error("shutdown relays differ");
   property p_fault_follow;
      $rose(chan_fail[0]) |-> ##[1:8] fault_relay[0];
   endproperty
   a_fault_follow: assert property (p_fault_follow)
      else $error("fault relay missing");
   property p_fail_trip;
      chan_fail[0] && chan_fail[1] |-> ##[1:8] shutdown_relay[0];
   endproperty
   a_fail_trip: assert property (p_fail_trip)
      else $error("double failure did not trip");
   property p_latch_hold;
      $fell(shutdown_relay[0]) || $fell(overspeed_alarm) |-> age_reg < 4'hc;
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch released without reset");
   property p_trip_alarm;
      shutdown_relay[0] && $stable(shutdown_relay[0]) && fault_relay == '0
         |-> overspeed_alarm || $past(overspeed_alarm);
   endproperty
   a_trip_alarm: assert property (p_trip_alarm)
      else $error("trip without alarm");
   property p_peak_hold;
      peak_speed < $past(peak_speed) |-> age_reg < 4'hc;
   endproperty
   a_peak_hold: assert property (p_peak_hold)
      else $error("peak dropped without reset");
endmodule : ovt_chk

// ===== test/ovt_pickup.sv
module ovt_pickup
   import ovt_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [NCH-1:0][7:0] period,
   output logic [NCH-1:0] pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [NCH-1:0][7:0] cnt_reg;
   // Square wave per circuit, still and low at period zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         pulse <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (period[i] == 8'h00 || cnt_reg[i] >= period[i] - 8'h01) begin
               cnt_reg[i] <= 8'h00;
            end else begin
               cnt_reg[i] <= cnt_reg[i] + 8'h01;
            end
            pulse[i] <= period[i] != 8'h00 && cnt_reg[i] < (period[i] >> 1);
         end
      end
   end
endmodule : ovt_pickup

// ===== test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ovt_pkg::*;
   localparam int G = 100;
   typedef struct {
      logic key;
      logic [7:0] a;
      logic [31:0] d;
      logic [1:0] w_exp;
      logic [1:0] r_exp;
      logic [31:0] d_exp;
   } ovt_row_t;
   logic clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, manual_reset, access_key;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, overspeed_alarm;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [NCH-1:0] sensor_pulse, test_freq_in, chan_fail;
   logic [NCH-1:0] shutdown_relay, fault_relay;
   logic [NCH-1:0][SPD_W-1:0] speed_readout;
   logic [SPD_W-1:0] peak_speed;
   logic [NCH-1:0][7:0] sp_per, tf_per;
   int error_cnt = 0;
   int n_compared = 0;
   ovt_row_t rows[6] = '{
      '{1'h0, OFS_SETPT0, 32'h0000000a, RESP_SLVERR, RESP_OKAY, 32'h00000fa0},
      '{1'h0, OFS_CTRL, 32'h00000001, RESP_SLVERR, RESP_OKAY, 32'h00000000},
      '{1'h1, OFS_SETPT0, 32'h0000000a, RESP_OKAY, RESP_OKAY, 32'h0000000a},
      '{1'h1, 8'h10, 32'h1234000a, RESP_OKAY, RESP_OKAY, 32'h0000000a},
      '{1'h1, 8'h14, 32'h0000000a, RESP_OKAY, RESP_OKAY, 32'h0000000a},
      '{1'h1, 8'h3c, 32'h00000005, RESP_DECERR, RESP_DECERR, 32'h00000000}};

   ovt_top #(.GATE_CYC(G)) uut (.*);
   ovt_pickup u_sens (.clk, .nrst, .period(sp_per), .pulse(sensor_pulse));
   ovt_pickup u_gen (.clk, .nrst, .period(tf_per), .pulse(test_freq_in));

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task summarize;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task wait_for(input logic done, input int k);
      if (!done && k > 60) begin
         error_cnt++;
         $display("timeout at %0t", $time);
         summarize;
      end
   endtask : wait_for

   // Bus write, both channels offered together
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Each channel released at the edge that takes it
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         k++;
         wait_for(s_axi_bvalid, k);
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int k;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         k++;
         wait_for(s_axi_rvalid, k);
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd

   task mreset;
      manual_reset <= 1'b1;
      cyc(1);
      manual_reset <= 1'b0;
      cyc(12);
   endtask : mreset

   task wait_trip;
      for (int k = 0; shutdown_relay[0] !== 1'b1; k++) begin
         wait_for(1'b0, k * 60 / (2 * G + 10));
         @(posedge clk);
      end
   endtask : wait_trip

   // Main sequence
   initial begin
      nrst = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, manual_reset, access_key} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      chan_fail = 3'h0;
      sp_per = '0;
      tf_per = '0;
      cyc(2);
      nrst <= 1'b1;
      cyc(2);
      chk({shutdown_relay, fault_relay, overspeed_alarm}, 0);
      foreach (rows[i]) begin
         access_key <= rows[i].key;
         cyc(4);
         wr(rows[i].a, rows[i].d, r);
         chk(r, rows[i].w_exp);
         rd(rows[i].a, d, r);
         chk(r, rows[i].r_exp);
         if (r === RESP_OKAY) chk(d, rows[i].d_exp);
      end
      $display("test registers done");
      sp_per <= {8'h14, 8'h14, 8'h04};
      cyc(3 * G);
      chk(overspeed_alarm, 1);
      chk(shutdown_relay, 0);
      chk(speed_readout[0], 32'h19);
      chk(speed_readout[1], 32'h05);
      chk(speed_readout[2], 32'h05);
      chk(peak_speed, 32'h19);
      sp_per <= {8'h14, 8'h04, 8'h04};
      wait_trip;
      cyc(2);
      chk(shutdown_relay, 3'h7);
      mreset;
      chk(shutdown_relay, 3'h7);
      sp_per <= {3{8'h14}};
      cyc(3 * G);
      chk(shutdown_relay, 3'h7);
      mreset;
      chk({shutdown_relay, overspeed_alarm}, 0);
      $display("test vote done");
      access_key <= 1'b0;
      cyc(4);
      wr(OFS_CMD, 32'h2, r);
      rd(OFS_PEAK, d, r);
      chk(d, 32'h19);
      access_key <= 1'b1;
      cyc(4);
      wr(OFS_CMD, 32'h2, r);
      rd(OFS_PEAK, d, r);
      chk(d, 32'h05);
      $display("test peak done");
      wr(OFS_CTRL, 32'h1, r);
      sp_per <= {8'h14, 8'h14, 8'h04};
      wait_trip;
      sp_per <= {3{8'h14}};
      cyc(3 * G);
      wr(OFS_CMD, 32'h1, r);
      cyc(2);
      chk(shutdown_relay, 0);
      wr(OFS_CTRL, 32'h0, r);
      $display("test two circuit done");
      chan_fail <= 3'h1;
      cyc(10);
      chk(fault_relay, 3'h1);
      chk(shutdown_relay, 0);
      chan_fail <= 3'h3;
      cyc(10);
      chk(shutdown_relay, 3'h7);
      chan_fail <= 3'h0;
      cyc(4);
      mreset;
      chk({shutdown_relay, fault_relay}, 0);
      $display("test failures done");
      wr(OFS_CTRL, 32'h2, r);
      tf_per <= {3{8'h04}};
      wr(OFS_CMD, 32'h4, r);
      cyc(8 * G);
      rd(OFS_STATUS, d, r);
      chk(d[18:15], 4'he);
      mreset;
      chk({shutdown_relay, overspeed_alarm}, 0);
      $display("test automatic done");
      wr(OFS_CTRL, 32'h10, r);
      tf_per <= {8'h00, 8'h00, 8'h04};
      cyc(2 * G + 10);
      chk(speed_readout[0], 32'h19);
      access_key <= 1'b0;
      cyc(4);
      wr(OFS_CTRL, 32'h0, r);
      chk(r, RESP_SLVERR);
      rd(OFS_CTRL, d, r);
      chk(d, 32'h10);
      $display("test online test done");
      summarize;
   end
endmodule : testbench

bind ovt_top ovt_chk u_chk (.*);
